// ===== src/sxs_pkg.sv
// Overview of operation
// - Sign extend copies the field's top bit into all bits above the field.
// - Field select 0 takes width setting a, select 1 takes setting b.
// - Sign extend sets zero and negative from result; carry, overflow unchanged.
// - Constant arithmetic shift moves destination left by 0 to 31, same register.
// - Shift count is the 5-bit field inside the instruction word.
// - Vacated low bits fill with zero.
// - Carry takes last bit shifted out; cleared for a zero count.
// - Overflow set when result sign or any shifted-out bit differs from old sign.
// - After shift, zero and negative flags follow the stored result.
// - A field-size code of zero means a 32-bit field.
package sxs_pkg;

  localparam int DATA_W    = 32;
  localparam int FS_W      = 5;
  localparam int REG_IDX_W = 5;

  // Instruction word fields
  localparam int OPC_HI    = 15;
  localparam int OPC_LO    = 10;
  localparam int SEL_BIT   = 9;
  localparam int ONE_BIT   = 8;
  localparam int ZRO_HI    = 7;
  localparam int ZRO_LO    = 5;
  localparam int CNT_HI    = 9;
  localparam int CNT_LO    = 5;
  localparam int FILE_BIT  = 4;
  localparam int DST_HI    = 3;
  localparam int DST_LO    = 0;

  localparam logic [5:0] OPC_SIGN_EXTEND_OP = 6'h01;
  localparam logic [5:0] OPC_SLAK = 6'h08;

  localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;

  typedef struct packed {
    logic n;
    logic c;
    logic z;
    logic v;
  } sxs_flags_t;

  localparam sxs_flags_t FLAGS_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } sxs_state_t;

endpackage : sxs_pkg

// ===== src/sxs_regfile.sv
`timescale 1ns/100ps
module sxs_regfile #(
  parameter int DW = 32,
  parameter int AW = 5
) (
  // Clock
  input  wire logic          clk,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : sxs_regfile

// ===== src/sxs_unit.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module sxs_unit
  import sxs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Instruction from decoder
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr,
  // Field width settings from status word
  input  wire logic [FS_W-1:0]   field_width_setting_a,
  input  wire logic [FS_W-1:0]   field_width_setting_b,
  // Register preload / readback port
  input  wire logic              ext_we,
  input  wire logic [4:0]        ext_addr,
  input  wire logic [31:0]       ext_wdata,
  input  wire logic              ext_re,
  output logic      [31:0]       ext_rdata,
  // Status
  output sxs_flags_t             flags,
  output logic                   busy,
  output logic                   done,
  output logic                   illegal
);

  // ==========================================================
  // Functions
  function automatic logic [5:0] fs_width(input logic [FS_W-1:0] code);
    fs_width = (code == '0) ? 6'h20 : {1'b0, code};
  endfunction : fs_width

  function automatic logic is_zero(input logic [31:0] val);
    is_zero = (val == 32'h0000_0000);
  endfunction : is_zero

  // ==========================================================
  // Decode
  logic dec_sign_extend_op;
  logic dec_sla;
  always_comb begin
    dec_sign_extend_op = (instr[OPC_HI:OPC_LO] == OPC_SIGN_EXTEND_OP) && instr[ONE_BIT]
               && (instr[ZRO_HI:ZRO_LO] == 3'h0);
    dec_sla  = (instr[OPC_HI:OPC_LO] == OPC_SLAK);
  end

  // ==========================================================
  // Sequencer and operation latch
  sxs_state_t      st_q, st_d;
  logic            op_sign_extend_op_q, op_sign_extend_op_d;
  logic            sel_q, sel_d;
  logic [4:0]      cnt_q, cnt_d;
  logic [4:0]      dst_q, dst_d;
  logic            busy_q, busy_d;
  logic            done_q, done_d;
  logic            ill_q, ill_d;
  logic            rd_pend_q, rd_pend_d;
  logic [31:0]     rd_q, rd_d;
  sxs_flags_t      fl_q, fl_d;
  logic [31:0]     rf_rdata;
  logic [31:0]     res;
  sxs_flags_t      res_fl;

  // ==========================================================
  // Datapath
  always_comb begin
    logic [5:0]  w;
    logic [31:0] mask;
    logic [63:0] wide;
    logic [31:0] outbits;
    logic        sgn;
    w = '0;
    mask = '0;
    wide = '0;
    outbits = '0;
    sgn = rf_rdata[31];
    res = rf_rdata;
    res_fl = fl_q;
    if (op_sign_extend_op_q) begin
      w = sel_q ? fs_width(field_width_setting_b)
                : fs_width(field_width_setting_a);
      // A full-width field passes the register through untouched
      mask = (w == 6'h20) ? 32'hffff_ffff : ((32'h0000_0001 << w[4:0]) - 32'h0000_0001);
      if (w != 6'h20 && rf_rdata[w[4:0] - 5'h1]) begin
        res = rf_rdata | ~mask;
      end else begin
        res = rf_rdata & mask;
      end
      res_fl.n = res[31];
      res_fl.z = is_zero(res);
    end else begin
      wide = {32'h0000_0000, rf_rdata} << cnt_q;
      res = wide[31:0];
      res_fl.c = (cnt_q == 5'h00) ? 1'b0 : wide[32];
      // Bits leaving the top plus the new sign must all match the old sign
      outbits = wide[63:32] | (sgn ? ~((32'h0000_0001 << cnt_q) - 32'h0000_0001) : 32'h0);
      res_fl.v = (res[31] != sgn) ||
                 (sgn ? (outbits != 32'hffff_ffff) : (wide[63:32] != 32'h0));
      res_fl.n = res[31];
      res_fl.z = is_zero(res);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    op_sign_extend_op_d = op_sign_extend_op_q;
    sel_d = sel_q;
    cnt_d = cnt_q;
    dst_d = dst_q;
    busy_d = busy_q;
    done_d = 1'b0;
    ill_d = 1'b0;
    fl_d = fl_q;
    // Readback is captured the cycle after the strobe
    rd_pend_d = ext_re;
    rd_d = rd_pend_q ? rf_rdata : rd_q;
    case (st_q)
      ST_IDLE: begin
        if (instr_valid) begin
          if (dec_sign_extend_op || dec_sla) begin
            op_sign_extend_op_d = dec_sign_extend_op;
            sel_d = instr[SEL_BIT];
            cnt_d = instr[CNT_HI:CNT_LO];
            dst_d = {instr[FILE_BIT], instr[DST_HI:DST_LO]};
            busy_d = 1'b1;
            st_d = ST_READ;
          end else begin
            ill_d = 1'b1;
          end
        end
      end
      ST_READ: begin
        st_d = ST_WRITE;
      end
      ST_WRITE: begin
        fl_d = res_fl;
        busy_d = 1'b0;
        done_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      op_sign_extend_op_q <= 1'b0;
      sel_q <= 1'b0;
      cnt_q <= 5'h00;
      dst_q <= 5'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      fl_q <= FLAGS_RST;
      rd_pend_q <= 1'b0;
      rd_q <= REG_RST;
    end else begin
      st_q <= st_d;
      op_sign_extend_op_q <= op_sign_extend_op_d;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      dst_q <= dst_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ill_q <= ill_d;
      fl_q <= fl_d;
      rd_pend_q <= rd_pend_d;
      rd_q <= rd_d;
    end
  end

  // ==========================================================
  // Register file: operation has priority over the external port
  logic        rf_we;
  logic [4:0]  rf_waddr;
  logic [4:0]  rf_raddr;
  logic [31:0] rf_wdata;
  always_comb begin
    rf_we    = ext_we;
    rf_waddr = ext_addr;
    rf_wdata = ext_wdata;
    rf_raddr = ext_addr;
    if (st_q == ST_WRITE) begin
      rf_we    = 1'b1;
      rf_waddr = dst_q;
      rf_wdata = res;
    end
    // Operand is read on acceptance and again in the read state, so the datapath
    // never sees the external address; a readback strobed then returns the operand
    if (st_q == ST_IDLE && instr_valid) begin
      rf_raddr = {instr[FILE_BIT], instr[DST_HI:DST_LO]};
    end else if (st_q == ST_READ) begin
      rf_raddr = dst_q;
    end
  end

  sxs_regfile #(
    .DW (DATA_W),
    .AW (REG_IDX_W)
  ) u_rf (
    .clk   (clk),
    .raddr (rf_raddr),
    .rdata (rf_rdata),
    .we    (rf_we),
    .waddr (rf_waddr),
    .wdata (rf_wdata)
  );

  // ==========================================================
  // Outputs
  assign ext_rdata = rd_q;
  assign flags     = fl_q;
  assign busy      = busy_q;
  assign done      = done_q;
  assign illegal   = ill_q;

endmodule : sxs_unit

// ===== verif/sxs_dec_model.sv
`timescale 1ns/100ps
// ===========
// Decoder model
module sxs_dec_model (
  // Clock input
  input  wire logic        clk,
  // Instruction to the unit
  output logic             instr_valid,
  output logic [15:0]      instr
);
  initial begin
    instr_valid = 1'b0;
    instr       = 16'h0000;
  end
  // Released word is inverted so stale bits never look valid
  task automatic issue(input logic [15:0] w);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    instr       <= ~w;
  endtask : issue
endmodule : sxs_dec_model

// ===== verif/sxs_unit_asserts.sv
`timescale 1ns/100ps
// ===========
// Checker
module sxs_unit_chk (
  // Clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // Instruction
  input wire logic               instr_valid,
  input wire logic [15:0]        instr,
  // Status
  input wire sxs_pkg::sxs_flags_t flags,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               illegal
);
  import sxs_pkg::*;
  logic tk, sx, sl;
  assign tk = instr_valid && !busy;
  assign sx = instr[15:10] == 6'h01 && instr[8] && instr[7:5] == 3'h0;
  assign sl = instr[15:10] == 6'h08;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  op_done_a:
    assert property (tk && (sx || sl) |-> ##3 done) else $error("Op late");
  busy_span_a:
    assert property (tk && (sx || sl) |=> busy [*2] ##1 !busy) else $error("Busy span");
  bad_opcode_a:
    assert property (tk && !(sx || sl) |=> illegal && !busy) else $error("No illegal");
  sign_extend_op_keeps_cv_a:
    assert property (tk && sx |-> ##3 flags.c == $past(flags.c, 3)
      && flags.v == $past(flags.v, 3)) else $error("Carry or overflow moved");
  zero_count_a:
    assert property (tk && sl && instr[9:5] == 5'h00 |-> ##3 !flags.c && !flags.v)
      else $error("Zero count flags");
  flags_hold_a:
    assert property (!done |-> $stable(flags)) else $error("Flags moved");
  done_pulse_a:
    assert property (done |=> !done) else $error("Done too long");
  zero_not_neg_a:
    assert property (done && flags.z |-> !flags.n) else $error("Zero and negative");
  cover property (tk && sx);
  cover property (tk && sl && instr[9:5] == 5'h1f);
  cover property (illegal);
endmodule : sxs_unit_chk
bind sxs_unit sxs_unit_chk chk_u (.clk(clk), .resetn(resetn), .instr_valid(instr_valid),
  .instr(instr), .flags(flags), .busy(busy), .done(done), .illegal(illegal));

// ===== verif/testbench.sv
`timescale 1ns/100ps
// ===========
// Testbench
module testbench;
  import sxs_pkg::*;
  logic        clk, resetn, ext_we, ext_re, instr_valid, busy, done, illegal;
  logic [15:0] instr;
  logic [4:0]  fa, fb, ext_addr;
  logic [31:0] ext_wdata, ext_rdata;
  sxs_flags_t  flags;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  sxs_unit dut_u (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
    .field_width_setting_a(fa), .field_width_setting_b(fb), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_re(ext_re), .ext_rdata(ext_rdata),
    .flags(flags), .busy(busy), .done(done), .illegal(illegal));
  sxs_dec_model dec_u (.clk(clk), .instr_valid(instr_valid), .instr(instr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check
  // Preload, move the port address off the operand, run one op,
  // then compare latency, flags and the written register
  task automatic run(input logic [31:0] d, input logic [15:0] w, input logic [4:0] a,
                     input logic [4:0] b, input logic [31:0] r, input logic [3:0] f);
    int t;
    @(posedge clk);
    ext_we    <= 1'b1;
    ext_addr  <= w[4:0];
    ext_wdata <= d;
    fa        <= a;
    fb        <= b;
    @(posedge clk);
    ext_we    <= 1'b0;
    ext_addr  <= ~w[4:0];
    ext_wdata <= ~d;
    dec_u.issue(w);
    t = 0;
    while (done !== 1'b1 && t < 10) begin
      @(posedge clk);
      #1;
      t++;
    end
    check(t, 2);
    check({28'h0000_000, flags}, {28'h0000_000, f});
    @(posedge clk);
    ext_re   <= 1'b1;
    ext_addr <= w[4:0];
    @(posedge clk);
    ext_re <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(ext_rdata, r);
  endtask : run
  initial begin
    {resetn, ext_we, ext_re, ext_addr, ext_wdata, fa, fb} = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    run(32'hcccc_cccc, 16'h2001, 5'h00, 5'h00, 32'hcccc_cccc, 4'h8);
    run(32'hcccc_cccc, 16'h2022, 5'h00, 5'h00, 32'h9999_9998, 4'hc);
    run(32'h0000_8000, 16'h0505, 5'h11, 5'h10, 32'h0000_8000, 4'h4);
    run(32'h3333_3333, 16'h2053, 5'h00, 5'h00, 32'hcccc_cccc, 4'h9);
    run(32'h0000_8000, 16'h0716, 5'h11, 5'h10, 32'hffff_8000, 4'h9);
    run(32'hcccc_cccc, 16'h2044, 5'h00, 5'h00, 32'h3333_3330, 4'h5);
    run(32'h0000_8000, 16'h0510, 5'h0f, 5'h10, 32'h0000_0000, 4'h7);
    run(32'h8000_0000, 16'h0703, 5'h11, 5'h00, 32'h8000_0000, 4'hd);
    run(32'hcccc_cccc, 16'h23ff, 5'h00, 5'h00, 32'h0000_0000, 4'h3);
    dec_u.issue(16'h0520);
    #1 check({31'h0000_0000, illegal}, 32'h0000_0001);
    finish_test();
  end
endmodule : testbench
